// ---- rtl/fcs_regs.vh ----
// Purpose: Constants for the flash command, reset and boot sequencer.
// Assumes: A 250 MHz core clock; all times are typical figures, at or under the maximum.
// Notes:   Included by bare name from the sequencer files.
`ifndef FCS_REGS_VH
`define FCS_REGS_VH

// ----------------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------------
`define CLK_MHZ          250
`define T_LD_SECT_US     23
`define T_LD_PAGE_US     30
`define T_PRG_SECT_US    205
`define T_PRG_PAGE_US    220
`define T_OTP_NS         500
`define T_LOCK_NS        500
`define T_ESP_US         400
`define T_ERS1_US        2000
`define T_ERS2_US        4000
`define T_VFY_US         70
`define T_BOOT_WAIT_US   400
`define T_BOOT_COPY_US   70
`define T_RDY1_US        5
`define T_RDY2_US        10

// ----------------------------------------------------------------------------
// Register map and boot partition
// ----------------------------------------------------------------------------
`define A_ADDR_REG       16'hF100
`define A_BLKCNT_REG     16'hF101
`define A_CMD_REG        16'hF220
`define A_STATUS_REG     16'hF240
`define A_INT_REG        16'hF241
`define BP_LO_FIRST      16'h0000
`define BP_LO_LAST       16'h01FF
`define BP_HI_FIRST      16'h8000
`define BP_HI_LAST       16'h800F
`define BP_HI_BASE       10'h0200

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define ST_BUSY_BIT      15
`define ST_SUSP_BIT      10
`define ST_OTP_BIT       9
`define ST_BOOT_BIT      7
`define INT_BIT          15
`define LOCK_NONE        2'h0
`define LOCK_LOCKED      2'h1
`define LOCK_TIGHT       2'h2
`define RST_WORD         16'h0000
`define RST_BLKCNT       7'h01

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define CMD_LD_SECT      16'h0000
`define CMD_LD_PAGE      16'h0013
`define CMD_PRG_SECT     16'h0080
`define CMD_PRG_PAGE     16'h001A
`define CMD_ERASE        16'h0094
`define CMD_ESUSP        16'h00B0
`define CMD_ERESUME      16'h0030
`define CMD_VERIFY       16'h0071
`define CMD_OTP          16'h0065
`define CMD_LOCK         16'h002A
`define CMD_UNLOCK       16'h0023
`define CMD_LOCKT        16'h002C
`define CMD_HOT_REG      16'h00F3
`define CMD_HOT_BP       16'h00F0

`endif

// ---- rtl/fcs_timer.v ----
// Purpose: Loadable down-counter that times one internal operation.
// Assumes: load_val is at least one.
// Notes:   done pulses one cycle after the last counted cycle.
`timescale 1ns/1ns
`default_nettype none

module fcs_timer (
  input  wire        clk,
  input  wire        reset,
  input  wire        start,
  input  wire        stop,
  input  wire [23:0] load_val,
  output reg         done
);

  reg [23:0] cnt_q;
  reg        run_q;

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      cnt_q <= 24'h00_0000;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= load_val;
        run_q <= 1'b1;
      end else if (stop) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (cnt_q == 24'h00_0001) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 24'h00_0001;
        end
      end
    end
  end

endmodule // fcs_timer

`default_nettype wire

// ---- rtl/fcs_seq.v ----
// Purpose: Command, reset and boot sequencer behind the host memory port.
// Assumes: Host pins are asynchronous and pass two flops; boot buffer storage sits outside.
// Notes:   Staging buffer storage is outside this block, so resets never touch it.
//
// Behaviour
// - Sector load completes and reports done within 35 us.
// - Page load completes and reports done within 45 us.
// - Sector program completes within 720 us.
// - Page program completes within 750 us.
// - One-time-programmable area access completes within 700 ns.
// - Lock, unlock and lock-tight complete within 700 ns.
// - Erase suspend stops erase and frees device within 500 us.
// - Resumed erase ends within 3 ms for one block, 6 ms for more.
// - Block erase within 3 ms single, 6 ms for up to 64 blocks.
// - Multi-block erase verify read finishes within 100 us.
// - Status shows in progress while running, complete when done.
// - Status reads answered in asynchronous and synchronous read modes.
// - Boot copy starts 400 us after power-on reset.
// - Boot copy of 1K bytes takes about 70 us; host reads after.
// - Cold reset interrupt rises when copy done and reset pin high.
// - After warm reset only boot reads until ready, then register operations.
// - Warm or hot reset reinitialises registers, keeps staging buffer.
// - Boot partition covers words 0000h-01FFh and 8000h-800Fh.
// - Hot reset is 00F0h into boot partition or 00F3h at F220h.
// - Boot buffer access ready within 5 us of a reset.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.vh"

module fcs_seq #(
  parameter [23:0] P_LD_SECT_CYC   = `T_LD_SECT_US * `CLK_MHZ,
  parameter [23:0] P_LD_PAGE_CYC   = `T_LD_PAGE_US * `CLK_MHZ,
  parameter [23:0] P_PRG_SECT_CYC  = `T_PRG_SECT_US * `CLK_MHZ,
  parameter [23:0] P_PRG_PAGE_CYC  = `T_PRG_PAGE_US * `CLK_MHZ,
  parameter [23:0] P_ESP_CYC       = `T_ESP_US * `CLK_MHZ,
  parameter [23:0] P_ERS1_CYC      = `T_ERS1_US * `CLK_MHZ,
  parameter [23:0] P_ERS2_CYC      = `T_ERS2_US * `CLK_MHZ,
  parameter [23:0] P_VFY_CYC       = `T_VFY_US * `CLK_MHZ,
  parameter [23:0] P_BOOT_WAIT_CYC = `T_BOOT_WAIT_US * `CLK_MHZ,
  parameter [23:0] P_BOOT_COPY_CYC = `T_BOOT_COPY_US * `CLK_MHZ
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        avd_n,
  input  wire [15:0] addr,
  input  wire [15:0] dq_in,
  output reg  [15:0] dq_out,
  output reg         dq_oe,
  input  wire        warm_reset_pin_n,
  output reg         int_flag,
  output reg  [9:0]  boot_raddr,
  input  wire [15:0] boot_rdata
);

  // --------------------------------------------------------------------------
  // Short counts and states
  // --------------------------------------------------------------------------
  localparam [23:0] OTP_CYC  = (`T_OTP_NS * `CLK_MHZ) / 1000;
  localparam [23:0] LOCK_CYC = (`T_LOCK_NS * `CLK_MHZ) / 1000;
  localparam [23:0] RDY1_CYC = `T_RDY1_US * `CLK_MHZ;
  localparam [23:0] RDY2_CYC = (`T_RDY2_US - `T_RDY1_US) * `CLK_MHZ;

  localparam [8:0] S_BOOTW = 9'h001;
  localparam [8:0] S_BOOTC = 9'h002;
  localparam [8:0] S_PINW  = 9'h004;
  localparam [8:0] S_IDLE  = 9'h008;
  localparam [8:0] S_BUSY  = 9'h010;
  localparam [8:0] S_SUSP  = 9'h020;
  localparam [8:0] S_RSTA  = 9'h040;
  localparam [8:0] S_RSTB  = 9'h080;
  localparam [8:0] S_RSTC  = 9'h100;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [36:0] sync1_q;
  reg  [36:0] sync2_q;
  reg         we_prev_q;
  reg  [15:0] alat_q;
  reg  [8:0]  st_q;
  reg  [8:0]  st_d;
  reg  [15:0] tgt_addr_q;
  reg  [6:0]  blkcnt_q;
  reg  [15:0] cmd_q;
  reg         erasing_q;
  reg         multi_q;
  reg         otp_q;
  reg  [1:0]  lock_q;
  reg         boot_done_q;
  reg         boot_armed_q;
  reg         tmr_start;
  reg  [23:0] tmr_val;
  reg         hot_rst;
  reg         accept_cmd;
  wire        tmr_done;
  wire        ce_s;
  wire        oe_s;
  wire        we_s;
  wire        avd_s;
  wire        pin_s;
  wire [15:0] dq_s;
  wire [15:0] a_s;
  wire        wr_stb;
  wire        rd_act;
  wire        boot_ok;
  wire        regs_ok;
  wire        hot_bp;
  wire        hot_reg;
  wire [15:0] status_word;

  function in_boot;
    input [15:0] a;
    begin
      in_boot = (a >= `BP_LO_FIRST && a <= `BP_LO_LAST) ||
                (a >= `BP_HI_FIRST && a <= `BP_HI_LAST);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers and write strobe
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      sync1_q   <= {5'h1F, 32'h0000_0000};
      sync2_q   <= {5'h1F, 32'h0000_0000};
      we_prev_q <= 1'b1;
      alat_q    <= `RST_WORD;
      boot_armed_q <= 1'b0;
    end else begin
      sync1_q   <= {ce_n, oe_n, we_n, avd_n, warm_reset_pin_n, dq_in, addr};
      sync2_q   <= sync1_q;
      we_prev_q <= we_s;
      boot_armed_q <= 1'b1;
      if (!ce_s && !avd_s) begin
        alat_q <= a_s;
      end
    end
  end

  assign ce_s   = sync2_q[36];
  assign oe_s   = sync2_q[35];
  assign we_s   = sync2_q[34];
  assign avd_s  = sync2_q[33];
  assign pin_s  = sync2_q[32];
  assign dq_s   = sync2_q[31:16];
  assign a_s    = sync2_q[15:0];
  assign wr_stb = !ce_s && we_s && !we_prev_q;
  assign rd_act = !ce_s && !oe_s && we_s;

  // Boot reads open once the copy is done and 5 us of reset recovery have run.
  assign boot_ok = boot_done_q && !(st_q == S_RSTA) && !(st_q == S_RSTB) &&
                   !(st_q == S_BOOTW) && !(st_q == S_BOOTC);
  assign regs_ok = (st_q == S_IDLE) || (st_q == S_BUSY) || (st_q == S_SUSP);
  assign hot_bp  = wr_stb && boot_ok && in_boot(alat_q) && dq_s == `CMD_HOT_BP;
  assign hot_reg = wr_stb && regs_ok && alat_q == `A_CMD_REG && dq_s == `CMD_HOT_REG;

  assign status_word = {(st_q == S_BUSY), 4'h0, (st_q == S_SUSP), otp_q, 1'b0,
                        boot_done_q, 5'h00, lock_q};

  // --------------------------------------------------------------------------
  // Next state and timer loads
  // --------------------------------------------------------------------------
  always @* begin
    st_d       = st_q;
    tmr_start  = 1'b0;
    tmr_val    = RDY1_CYC;
    hot_rst    = hot_bp || hot_reg;
    accept_cmd = wr_stb && alat_q == `A_CMD_REG;
    if (!pin_s && !(st_q == S_BOOTW) && !(st_q == S_BOOTC) && !(st_q == S_PINW)) begin
      st_d = S_RSTA;
    end else if (hot_rst) begin
      st_d      = S_RSTB;
      tmr_start = 1'b1;
      tmr_val   = RDY1_CYC;
    end else begin
      case (st_q)
        S_BOOTW: begin
          if (!boot_armed_q) begin
            tmr_start = 1'b1;
            tmr_val   = P_BOOT_WAIT_CYC;
          end else if (tmr_done) begin
            st_d      = S_BOOTC;
            tmr_start = 1'b1;
            tmr_val   = P_BOOT_COPY_CYC;
          end
        end
        S_BOOTC: begin
          if (tmr_done) begin
            st_d = pin_s ? S_IDLE : S_PINW;
          end
        end
        S_PINW: begin
          if (pin_s) begin
            st_d = S_IDLE;
          end
        end
        S_IDLE: begin
          if (accept_cmd) begin
            tmr_start = 1'b1;
            st_d      = S_BUSY;
            if (dq_s == `CMD_LD_SECT) begin
              tmr_val = P_LD_SECT_CYC;
            end else if (dq_s == `CMD_LD_PAGE) begin
              tmr_val = P_LD_PAGE_CYC;
            end else if (dq_s == `CMD_PRG_SECT) begin
              tmr_val = P_PRG_SECT_CYC;
            end else if (dq_s == `CMD_PRG_PAGE) begin
              tmr_val = P_PRG_PAGE_CYC;
            end else if (dq_s == `CMD_OTP) begin
              tmr_val = OTP_CYC;
            end else if (dq_s == `CMD_LOCK || dq_s == `CMD_UNLOCK || dq_s == `CMD_LOCKT) begin
              tmr_val = LOCK_CYC;
            end else if (dq_s == `CMD_ERASE) begin
              tmr_val = (blkcnt_q > `RST_BLKCNT) ? P_ERS2_CYC : P_ERS1_CYC;
            end else if (dq_s == `CMD_VERIFY) begin
              tmr_val = P_VFY_CYC;
            end else begin
              tmr_start = 1'b0;
              st_d      = S_IDLE;
            end
          end
        end
        S_BUSY: begin
          if (accept_cmd && erasing_q && dq_s == `CMD_ESUSP) begin
            tmr_start = 1'b1;
            tmr_val   = P_ESP_CYC;
          end else if (tmr_done) begin
            st_d = (erasing_q && cmd_q == `CMD_ESUSP) ? S_SUSP : S_IDLE;
          end
        end
        S_SUSP: begin
          if (accept_cmd && dq_s == `CMD_ERESUME) begin
            st_d      = S_BUSY;
            tmr_start = 1'b1;
            tmr_val   = multi_q ? P_ERS2_CYC : P_ERS1_CYC;
          end
        end
        S_RSTA: begin
          if (pin_s) begin
            st_d      = S_RSTB;
            tmr_start = 1'b1;
            tmr_val   = RDY1_CYC;
          end
        end
        S_RSTB: begin
          if (tmr_done) begin
            st_d      = S_RSTC;
            tmr_start = 1'b1;
            tmr_val   = RDY2_CYC;
          end
        end
        S_RSTC: begin
          if (tmr_done) begin
            st_d = S_IDLE;
          end
        end
        default: begin
          st_d = S_IDLE;
        end
      endcase
    end
  end

  fcs_timer u_timer (
    .clk      (clk),
    .reset    (reset),
    .start    (tmr_start),
    .stop     (st_d == S_RSTA),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // --------------------------------------------------------------------------
  // State, registers and interrupt flag
  // --------------------------------------------------------------------------
  // The boot wait timer is armed by the first cycle out of reset, so the copy
  // starts 400 us after the power-on reset is released.
  always @(posedge clk) begin
    if (reset) begin
      st_q        <= S_BOOTW;
      tgt_addr_q  <= `RST_WORD;
      blkcnt_q    <= `RST_BLKCNT;
      cmd_q       <= `RST_WORD;
      erasing_q   <= 1'b0;
      multi_q     <= 1'b0;
      otp_q       <= 1'b0;
      lock_q      <= `LOCK_NONE;
      boot_done_q <= 1'b0;
      int_flag    <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == S_BOOTC && tmr_done) begin
        boot_done_q <= 1'b1;
      end
      if (st_d == S_RSTA || (hot_rst && st_d == S_RSTB)) begin
        tgt_addr_q <= `RST_WORD;
        blkcnt_q   <= `RST_BLKCNT;
        cmd_q      <= `RST_WORD;
        erasing_q  <= 1'b0;
        multi_q    <= 1'b0;
        otp_q      <= 1'b0;
        lock_q     <= `LOCK_NONE;
        int_flag   <= 1'b0;
      end else begin
        if (wr_stb && st_q == S_IDLE && alat_q == `A_ADDR_REG) begin
          tgt_addr_q <= dq_s;
        end
        if (wr_stb && st_q == S_IDLE && alat_q == `A_BLKCNT_REG) begin
          blkcnt_q <= dq_s[6:0];
        end
        if (tmr_start && (st_q == S_IDLE || st_q == S_BUSY || st_q == S_SUSP)) begin
          cmd_q <= dq_s;
          if (st_q == S_IDLE) begin
            erasing_q <= (dq_s == `CMD_ERASE);
            multi_q   <= (blkcnt_q > `RST_BLKCNT);
          end
        end
        if (st_q == S_BUSY && tmr_done && !(erasing_q && cmd_q == `CMD_ESUSP)) begin
          erasing_q <= 1'b0;
          if (cmd_q == `CMD_OTP) begin
            otp_q <= 1'b1;
          end else if (cmd_q == `CMD_LOCK && lock_q != `LOCK_TIGHT) begin
            lock_q <= `LOCK_LOCKED;
          end else if (cmd_q == `CMD_UNLOCK && lock_q != `LOCK_TIGHT) begin
            lock_q <= `LOCK_NONE;
          end else if (cmd_q == `CMD_LOCKT && lock_q == `LOCK_LOCKED) begin
            lock_q <= `LOCK_TIGHT;
          end
        end
        // Completion beats a host clear in the same cycle so no done is lost.
        if ((st_d == S_IDLE || st_d == S_SUSP) && st_q != st_d) begin
          int_flag <= 1'b1;
        end else if (tmr_start && (st_q == S_IDLE || st_q == S_SUSP)) begin
          int_flag <= 1'b0;
        end else if (wr_stb && regs_ok && alat_q == `A_INT_REG) begin
          int_flag <= dq_s[`INT_BIT];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Reads are sampled on the core clock whatever the host bus mode, so burst
  // and asynchronous status reads return the same word, three cycles late.
  always @(posedge clk) begin
    if (reset) begin
      dq_out     <= `RST_WORD;
      dq_oe      <= 1'b0;
      boot_raddr <= 10'h000;
    end else begin
      dq_oe      <= rd_act;
      boot_raddr <= (alat_q >= `BP_HI_FIRST) ? (`BP_HI_BASE + {6'h00, alat_q[3:0]})
                                            : {1'b0, alat_q[8:0]};
      if (!rd_act) begin
        dq_out <= `RST_WORD;
      end else if (in_boot(alat_q)) begin
        dq_out <= boot_ok ? boot_rdata : `RST_WORD;
      end else if (!regs_ok) begin
        dq_out <= `RST_WORD;
      end else if (alat_q == `A_STATUS_REG) begin
        dq_out <= status_word;
      end else if (alat_q == `A_INT_REG) begin
        dq_out <= {int_flag, 15'h0000};
      end else if (alat_q == `A_ADDR_REG) begin
        dq_out <= tgt_addr_q;
      end else if (alat_q == `A_BLKCNT_REG) begin
        dq_out <= {9'h000, blkcnt_q};
      end else if (alat_q == `A_CMD_REG) begin
        dq_out <= cmd_q;
      end else begin
        dq_out <= `RST_WORD;
      end
    end
  end

endmodule // fcs_seq

`default_nettype wire

// ---- sim/fcs_host_model.sv ----
// Purpose: Host memory controller model driving the sequencer pins.
// Assumes: Asynchronous cycles; every pin state stands four clocks, except the read data phase, which stands six.
// Notes:   Released data and address lines show the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none

module fcs_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] dq_out,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             avd_n,
  output logic [15:0]      addr,
  output logic [15:0]      dq_in
);
  initial begin
    ce_n  = 1'b1;
    oe_n  = 1'b1;
    we_n  = 1'b1;
    avd_n = 1'b1;
    addr  = 16'h0000;
    dq_in = 16'h0000;
  end

  // Pins move just after an edge, so the synchroniser never sees a half change.
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    ce_n  = 1'b0;
    avd_n = 1'b0;
    addr  = a;
    step(4);
    avd_n = 1'b1;
    we_n  = 1'b0;
    dq_in = d;
    step(4);
    we_n = 1'b1;
    step(4);
    ce_n  = 1'b1;
    addr  = ~a;
    dq_in = ~d;
    step(4);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    ce_n  = 1'b0;
    avd_n = 1'b0;
    addr  = a;
    step(4);
    avd_n = 1'b1;
    oe_n  = 1'b0;
    step(6);
    d    = dq_out;
    oe_n = 1'b1;
    ce_n = 1'b1;
    addr = ~a;
    step(4);
  endtask
endmodule // fcs_host_model

`default_nettype wire

// ---- sim/fcs_seq_checker.sv ----
// Purpose: Pin-level assertions for the sequencer.
// Assumes: Boot counts are handed on from the bound instance.
// Notes:   Helper counters time boot and warm reset spans too long to unroll.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.vh"

module fcs_seq_checker #(
  parameter [23:0] P_BOOT_WAIT_CYC = `T_BOOT_WAIT_US * `CLK_MHZ,
  parameter [23:0] P_BOOT_COPY_CYC = `T_BOOT_COPY_US * `CLK_MHZ
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        avd_n,
  input wire logic [15:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe,
  input wire logic        warm_reset_pin_n,
  input wire logic        int_flag,
  input wire logic [9:0]  boot_raddr,
  input wire logic [15:0] boot_rdata
);
  localparam [24:0] LIM = P_BOOT_WAIT_CYC + P_BOOT_COPY_CYC;
  logic [24:0] cnt_q;
  logic [11:0] wait_q;
  logic        seen_q;
  logic        pin_q;

  // The warm counter restarts on each pin rise and clears once ready shows.
  always_ff @(posedge clk) begin
    pin_q <= warm_reset_pin_n;
    if (reset) begin
      cnt_q  <= 25'h0;
      wait_q <= 12'h000;
      seen_q <= 1'b0;
    end else begin
      if (cnt_q <= LIM) cnt_q <= cnt_q + 25'h1;
      if (int_flag) seen_q <= 1'b1;
      if (int_flag) wait_q <= 12'h000;
      else if (!pin_q && warm_reset_pin_n) wait_q <= 12'h001;
      else if (wait_q != 12'h000 && wait_q != 12'hFFF) wait_q <= wait_q + 12'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_BOOT_WAIT: assert property ((cnt_q < LIM) |-> !int_flag)
    else $error("ready flag before boot copy end");
  AST_BOOT_DONE: assert property ((cnt_q == LIM) && warm_reset_pin_n |-> ##[0:10] int_flag)
    else $error("ready flag late after boot copy");
  AST_LATE_PIN: assert property ((cnt_q > LIM) && !seen_q && $rose(warm_reset_pin_n)
    |-> ##[1:8] int_flag)
    else $error("ready flag late after reset pin rise");
  AST_LD: assert property ($rose(we_n) && !ce_n && addr == `A_CMD_REG && dq_in == `CMD_LD_SECT && int_flag
    |-> ##6 (!int_flag) [*8] ##8 !int_flag ##[1:20] int_flag)
    else $error("sector load flag timing wrong");
  AST_OTP_LOCK: assert property ($rose(we_n) && !ce_n && addr == `A_CMD_REG && int_flag
    && (dq_in == `CMD_OTP || dq_in == `CMD_LOCK || dq_in == `CMD_UNLOCK || dq_in == `CMD_LOCKT)
    |-> ##6 !int_flag ##[1:175] int_flag)
    else $error("short operation over its limit");
  AST_RD_OE: assert property ((!ce_n && !oe_n && we_n) [*4] |-> dq_oe)
    else $error("read not answered");
  AST_DESEL: assert property (ce_n [*4] |-> (!dq_oe && dq_out == 16'h0000))
    else $error("output not at default when deselected");
  AST_WARM_DROP: assert property (seen_q && int_flag && $fell(warm_reset_pin_n) |-> ##[1:5] !int_flag)
    else $error("warm reset did not clear ready flag");
  AST_WARM_RDY: assert property ($rose(int_flag) && seen_q && wait_q != 12'h000
    |-> (wait_q >= 12'h9BA && wait_q <= 12'h9D8))
    else $error("warm reset ready time wrong");
endmodule // fcs_seq_checker

bind fcs_seq fcs_seq_checker #(
  .P_BOOT_WAIT_CYC(P_BOOT_WAIT_CYC),
  .P_BOOT_COPY_CYC(P_BOOT_COPY_CYC)
) u_chk (
  .clk(clk), .reset(reset), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .avd_n(avd_n),
  .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .warm_reset_pin_n(warm_reset_pin_n), .int_flag(int_flag),
  .boot_raddr(boot_raddr), .boot_rdata(boot_rdata)
);

`default_nettype wire

// ---- sim/fcs_seq_tb.sv ----
// Purpose: Self-checking bench for the sequencer through its host pins.
// Assumes: Short operation counts; boot buffer word reads back its own index under a 2Ah tag in the top six bits.
// Notes:   Fixed waits only where the reset ready phases fix the count.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.vh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module fcs_seq_tb;
  localparam logic [23:0] BW = 24'h64, BC = 24'h32, LS = 24'h14, LP = 24'h1E, PS = 24'h28;
  localparam logic [23:0] PP = 24'h32, ES = 24'h19, E1 = 24'h3C, E2 = 24'h50, VF = 24'h23;
  logic             clk = 1'b0;
  logic             reset = 1'b1;
  logic             pin_n = 1'b1;
  wire logic        ce_n, oe_n, we_n, avd_n, dq_oe, int_flag;
  wire logic [15:0] addr, dq_in, dq_out, boot_rdata;
  wire logic [9:0]  boot_raddr;
  logic [15:0]      rv;
  logic [15:0]      ba [4] = '{16'h0000, 16'h01FF, 16'h8000, 16'h800F};
  logic [15:0]      bx [4] = '{16'hA800, 16'hA9FF, 16'hAA00, 16'hAA0F};
  int               num_errors = 0;
  int               n_tests = 0;

  always #2 clk = ~clk;
  assign boot_rdata = {6'h2A, boot_raddr};

  fcs_seq #(.P_LD_SECT_CYC(LS), .P_LD_PAGE_CYC(LP), .P_PRG_SECT_CYC(PS), .P_PRG_PAGE_CYC(PP),
    .P_ESP_CYC(ES), .P_ERS1_CYC(E1), .P_ERS2_CYC(E2), .P_VFY_CYC(VF), .P_BOOT_WAIT_CYC(BW),
    .P_BOOT_COPY_CYC(BC)) dut (
    .clk(clk), .reset(reset), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .avd_n(avd_n),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .warm_reset_pin_n(pin_n),
    .int_flag(int_flag), .boot_raddr(boot_raddr), .boot_rdata(boot_rdata));

  fcs_host_model host (.clk(clk), .dq_out(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .avd_n(avd_n), .addr(addr), .dq_in(dq_in));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_int(input int lim, output int n);
    n = 0;
    while (int_flag !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        `CHK("ready wait", 1'b1, 1'b0)
        final_report();
      end
    end
  endtask

  task automatic t_boot;
    int n;
    wait_int(BW + BC + 10, n);
    `CHK("boot copy span", 1'b1, n >= BW + BC)
    for (int i = 0; i < 4; i++) begin
      host.rd(ba[i], rv);
      `CHK("boot word", bx[i], rv)
    end
    host.rd(`A_STATUS_REG, rv);
    `CHK("boot done bit", 1'b1, rv[`ST_BOOT_BIT])
    host.wr(`A_INT_REG, 16'h0000);
    `CHK("int bit cleared", 1'b0, int_flag)
    host.wr(`A_INT_REG, 16'h8000);
    host.rd(`A_INT_REG, rv);
    `CHK("int bit set", 16'h8000, rv)
  endtask

  task automatic t_op(input logic [15:0] cmd, input logic [15:0] blk, input int nc);
    int n;
    host.wr(`A_ADDR_REG, 16'h0040);
    host.wr(`A_BLKCNT_REG, blk);
    host.wr(`A_CMD_REG, cmd);
    `CHK("flag low in op", 1'b0, int_flag)
    wait_int(nc + 4, n);
    `CHK("op not early", 1'b1, n + 8 >= nc)
    host.rd(`A_STATUS_REG, rv);
    `CHK("busy cleared", 1'b0, rv[`ST_BUSY_BIT])
  endtask

  task automatic t_susp(input logic [15:0] blk, input int nres);
    int n;
    host.wr(`A_BLKCNT_REG, blk);
    host.wr(`A_CMD_REG, `CMD_ERASE);
    host.rd(`A_STATUS_REG, rv);
    `CHK("erase in progress", 1'b1, rv[`ST_BUSY_BIT])
    host.wr(`A_CMD_REG, `CMD_ESUSP);
    wait_int(27, n);
    host.rd(`A_STATUS_REG, rv);
    `CHK("suspended bit", 1'b1, rv[`ST_SUSP_BIT])
    host.wr(`A_CMD_REG, `CMD_ERESUME);
    wait_int(nres + 4, n);
    `CHK("resume span", 1'b1, n + 8 >= nres)
  endtask

  task automatic t_warm;
    int n;
    host.rd(`A_STATUS_REG, rv);
    `CHK("tight lock", `LOCK_TIGHT, rv[1:0])
    pin_n = 1'b0;
    repeat (60) @(posedge clk);
    #1;
    pin_n = 1'b1;
    `CHK("warm flag low", 1'b0, int_flag)
    host.rd(`A_STATUS_REG, rv);
    `CHK("registers closed", 16'h0000, rv)
    repeat (1240) @(posedge clk);
    #1;
    host.rd(16'h0000, rv);
    `CHK("boot open", 16'hA800, rv)
    `CHK("still pending", 1'b0, int_flag)
    host.wr(`A_CMD_REG, `CMD_LOCK);
    wait_int(1300, n);
    host.rd(`A_STATUS_REG, rv);
    `CHK("lock cleared", `LOCK_NONE, rv[1:0])
  endtask

  task automatic t_hot(input logic [15:0] a, input logic [15:0] d);
    int n;
    host.wr(a, d);
    `CHK("hot flag low", 1'b0, int_flag)
    wait_int(2520, n);
    `CHK("hot ready span", 1'b1, n > 2480)
  endtask

  // A second power-on with the pin held low: ready must wait for the pin.
  task automatic t_cold_late;
    int n;
    reset = 1'b1;
    pin_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (BW + BC + 30) @(posedge clk);
    #1;
    `CHK("held by pin", 1'b0, int_flag)
    pin_n = 1'b1;
    wait_int(8, n);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    t_boot();
    t_op(`CMD_LD_SECT, 16'h0001, LS);
    t_op(`CMD_LD_PAGE, 16'h0001, LP);
    t_op(`CMD_PRG_SECT, 16'h0001, PS);
    t_op(`CMD_PRG_PAGE, 16'h0001, PP);
    t_op(`CMD_ERASE, 16'h0001, E1);
    t_op(`CMD_ERASE, 16'h0040, E2);
    t_op(`CMD_VERIFY, 16'h0040, VF);
    t_op(`CMD_OTP, 16'h0001, 125);
    t_susp(16'h0001, E1);
    t_susp(16'h0002, E2);
    t_op(`CMD_UNLOCK, 16'h0001, 125);
    t_op(`CMD_LOCK, 16'h0001, 125);
    t_op(`CMD_LOCKT, 16'h0001, 125);
    t_warm();
    t_hot(`A_CMD_REG, `CMD_HOT_REG);
    t_hot(16'h0010, `CMD_HOT_BP);
    t_op(`CMD_LD_SECT, 16'h0001, LS);
    t_cold_late();
    final_report();
  end

  initial begin
    repeat (60000) @(posedge clk);
    `CHK("watchdog", 1'b0, 1'b1)
    final_report();
  end
endmodule // fcs_seq_tb

`default_nettype wire
